// [logic/ewc_config.sv]
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module ewc_config (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic      [31:0] o_prdata,
  output logic             o_pslverr,
  // processor and bus cycles
  input  wire logic        i_cyc_start,
  input  wire logic [1:0]  i_cyc_kind,
  input  wire logic [2:0]  i_mem_waits,
  input  wire logic        i_processor_addr_line_20,
  input  wire logic        i_page_access,
  output logic             o_cyc_ready,
  output logic             o_system_addr_line_20,
  // memory mapping outputs
  output logic      [3:0]  o_page_io_base,
  output logic      [3:0]  o_frame_base,
  output logic      [7:0]  o_page_position,
  output logic      [2:0]  o_expanded_memory_size,
  output logic             o_expanded_memory_en,
  output logic             o_ras_timeout,
  // dma outputs
  output logic             o_dma_clk_en,
  output logic             o_dma_ext_strobe_en
);
  // ==========================================================
  // registers
  logic [7:0]  io_base_q;
  logic [7:0]  position_q;
  logic [7:0]  misc_q;
  logic [7:0]  clkws_q;
  logic        dma_div_q;
  logic [13:0] ras_cnt_q;
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [7:0]  rd_byte;
  logic [2:0]  waits;
  logic        tick;
  logic        busy;
  logic        done;
  logic [1:0]  last_kind_q;

  assign wr_en = i_psel && i_penable && i_pwrite && o_pready;
  assign rd_en = i_psel && i_penable && !i_pwrite && o_pready;
  assign addr_ok = (i_paddr == ewc_pkg::OFF_PAGE_IO_BASE) || (i_paddr == ewc_pkg::OFF_PAGE_POSITION) ||
                   (i_paddr == ewc_pkg::OFF_MISC_MEMORY) || (i_paddr == ewc_pkg::OFF_CLOCK_WAIT) ||
                   (i_paddr == ewc_pkg::OFF_STATUS);

  // ==========================================================
  // apb handshake: ready in the access phase, one wait-free answer
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
    end
  end

  // defaults at reset, write lands at the completing edge
  // io base field, frame base field
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      io_base_q <= {ewc_pkg::FRAME_RESET, ewc_pkg::IOB_RESET};
    end else if (wr_en && i_paddr == ewc_pkg::OFF_PAGE_IO_BASE) begin
      io_base_q[ewc_pkg::IOB_LSB +: 4] <= i_pwdata[3:0];
      // codes above 1000 have no frame, so they are clamped
      if (i_pwdata[7:4] > ewc_pkg::FRAME_MAX) begin
        io_base_q[ewc_pkg::FRAME_LSB +: 4] <= ewc_pkg::FRAME_MAX;
      end else begin
        io_base_q[ewc_pkg::FRAME_LSB +: 4] <= i_pwdata[7:4];
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      position_q <= ewc_pkg::POSITION_RESET;
    end else if (wr_en && i_paddr == ewc_pkg::OFF_PAGE_POSITION) begin
      position_q <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      misc_q <= ewc_pkg::MISC_RESET;
    end else if (wr_en && i_paddr == ewc_pkg::OFF_MISC_MEMORY) begin
      misc_q <= {2'h0, i_pwdata[5:0]};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      clkws_q <= ewc_pkg::CLOCK_WAIT_RESET;
    end else if (wr_en && i_paddr == ewc_pkg::OFF_CLOCK_WAIT) begin
      clkws_q <= i_pwdata[7:0];
    end
  end

  // ==========================================================
  // read mux; status shows busy, last cycle kind and timeout
  always_comb begin
    case (i_paddr)
      ewc_pkg::OFF_PAGE_IO_BASE:  rd_byte = io_base_q;
      ewc_pkg::OFF_PAGE_POSITION: rd_byte = position_q;
      ewc_pkg::OFF_MISC_MEMORY:   rd_byte = misc_q;
      ewc_pkg::OFF_CLOCK_WAIT:    rd_byte = clkws_q;
      ewc_pkg::OFF_STATUS:        rd_byte = {4'h0, o_ras_timeout, last_kind_q, busy};
      default:                    rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= 1'b0;
      if (i_psel && !i_penable) begin
        o_prdata  <= (!i_pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        o_pslverr <= !addr_ok;
      end
    end
  end

  // ==========================================================
  // registered copies of the fields drive the outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_page_io_base         <= ewc_pkg::IOB_RESET;
      o_frame_base           <= ewc_pkg::FRAME_RESET;
      o_page_position        <= ewc_pkg::POSITION_RESET;
      o_expanded_memory_size <= 3'h0;
      o_expanded_memory_en   <= 1'b0;
      o_dma_ext_strobe_en    <= 1'b0;
    end else begin
      o_page_io_base         <= io_base_q[ewc_pkg::IOB_LSB +: 4];
      o_frame_base           <= io_base_q[ewc_pkg::FRAME_LSB +: 4];
      // two bits per page select its 1M..8M region
      o_page_position        <= position_q;
      // 000 means half a megabyte, others whole megabytes
      o_expanded_memory_size <= misc_q[ewc_pkg::SIZE_LSB +: 3];
      o_expanded_memory_en   <= misc_q[ewc_pkg::EMEN_BIT];
      o_dma_ext_strobe_en    <= clkws_q[ewc_pkg::XSTB_BIT];
    end
  end

  // line 20 gate, one flop of latency
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_system_addr_line_20 <= 1'b0;
    end else begin
      o_system_addr_line_20 <= i_processor_addr_line_20 && !misc_q[ewc_pkg::A20_BIT];
    end
  end

  // ==========================================================
  // row strobe timeout: counts page hold time while enabled
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ras_cnt_q     <= 14'h0000;
      o_ras_timeout <= 1'b0;
    end else if (!misc_q[ewc_pkg::RAS_BIT] || !i_page_access) begin
      ras_cnt_q     <= 14'h0000;
      o_ras_timeout <= 1'b0;
    end else if (ras_cnt_q == 14'(ewc_pkg::RAS_TIMEOUT_CYC - 1)) begin
      o_ras_timeout <= 1'b1;
    end else begin
      ras_cnt_q <= ras_cnt_q + 14'h0001;
    end
  end

  // ==========================================================
  // dma clock enable: every cycle, or every second one
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      // divider starts high so the first enable after reset already alternates
      dma_div_q    <= 1'b1;
      o_dma_clk_en <= 1'b0;
    end else begin
      dma_div_q    <= !dma_div_q;
      o_dma_clk_en <= clkws_q[ewc_pkg::DCLK_BIT] ? 1'b1 : dma_div_q;
    end
  end

  // ==========================================================
  // wait count per cycle kind
  always_comb begin
    waits = 3'h0;
    case (ewc_pkg::ewc_cyc_t'(i_cyc_kind))
      // expanded memory forces one wait on local memory
      ewc_pkg::EWC_CYC_MEM:   waits = misc_q[ewc_pkg::EMEN_BIT] ? ewc_pkg::EMS_MEM_WAITS : i_mem_waits;
      // io waits are code plus one
      ewc_pkg::EWC_CYC_IO:    waits = {1'b0, clkws_q[ewc_pkg::IOWS_LSB +: 2]} + 3'h1;
      ewc_pkg::EWC_CYC_DMA16: waits = {1'b0, clkws_q[ewc_pkg::DMA16_LSB +: 2]} + 3'h1;
      ewc_pkg::EWC_CYC_DMA8:  waits = {1'b0, clkws_q[ewc_pkg::DMA8_LSB +: 2]} + 3'h1;
      default:                waits = 3'h0;
    endcase
  end

  // dma waits count dma clocks, others system clocks
  // kind is held from the taking edge, since the bus may change it while the cycle runs
  assign tick = (last_kind_q[1]) ? o_dma_clk_en : 1'b1;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      last_kind_q <= 2'h0;
    end else if (i_cyc_start && !busy) begin
      last_kind_q <= i_cyc_kind;
    end
  end

  // cycle completes after the chosen wait periods
  ewc_wait_gen u_wait (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_start (i_cyc_start),
    .i_waits (waits),
    .i_tick  (tick),
    .o_busy  (busy),
    .o_done  (done)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cyc_ready <= 1'b0;
    end else begin
      o_cyc_ready <= done;
    end
  end

  // ==========================================================
  // checks
  // line 20 forced low while the gate bit is set, passed through while it is clear
  a_line20_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    misc_q[ewc_pkg::A20_BIT] |=> !o_system_addr_line_20)
    else $error("line 20 not forced low");
  a_line20_pass: assert property (@(posedge i_clk) disable iff (i_rst)
    !misc_q[ewc_pkg::A20_BIT] |=> o_system_addr_line_20 == $past(i_processor_addr_line_20))
    else $error("line 20 not passed");
  // one wait under expanded memory on memory cycles
  a_ems_one_wait: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cyc_start && !busy && i_cyc_kind == 2'h0 && misc_q[ewc_pkg::EMEN_BIT]) |=> ##1 !done ##1 done)
    else $error("memory cycle not one wait");
  // io cycle with code 11 lasts four waits
  a_io_four_waits: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_cyc_start && !busy && i_cyc_kind == 2'h1 && clkws_q[1:0] == 2'h3) |=> (!done) [*5] ##1 done)
    else $error("io waits wrong");
  a_dma_clk_full: assert property (@(posedge i_clk) disable iff (i_rst)
    clkws_q[ewc_pkg::DCLK_BIT] |=> o_dma_clk_en)
    else $error("dma clock not undivided");
  a_dma_clk_half: assert property (@(posedge i_clk) disable iff (i_rst)
    (!clkws_q[ewc_pkg::DCLK_BIT] && $past(!clkws_q[ewc_pkg::DCLK_BIT])) |=> o_dma_clk_en != $past(o_dma_clk_en))
    else $error("dma clock not halved");
  a_ras_disabled: assert property (@(posedge i_clk) disable iff (i_rst)
    !misc_q[ewc_pkg::RAS_BIT] |=> !o_ras_timeout)
    else $error("timeout while disabled");
  // written io base appears two edges later
  a_write_lands: assert property (@(posedge i_clk) disable iff (i_rst)
    (wr_en && i_paddr == ewc_pkg::OFF_PAGE_IO_BASE) |=> ##1 o_page_io_base == $past(i_pwdata[3:0], 2))
    else $error("io base write lost");
  a_frame_range: assert property (@(posedge i_clk) disable iff (i_rst)
    o_frame_base <= ewc_pkg::FRAME_MAX)
    else $error("frame base out of range");
  c_io_cycle:  cover property (@(posedge i_clk) i_cyc_start && !busy && i_cyc_kind == 2'h1);
  c_dma8:      cover property (@(posedge i_clk) i_cyc_start && !busy && i_cyc_kind == 2'h3);
  c_ras_fire:  cover property (@(posedge i_clk) o_ras_timeout);
  c_bad_addr:  cover property (@(posedge i_clk) o_pslverr);
endmodule
`default_nettype wire

// [logic/ewc_pkg.sv]
package ewc_pkg;
  // register byte offsets on the APB bus
  localparam logic [11:0] OFF_PAGE_IO_BASE  = 12'h0_000;
  localparam logic [11:0] OFF_PAGE_POSITION = 12'h0_004;
  localparam logic [11:0] OFF_MISC_MEMORY   = 12'h0_008;
  localparam logic [11:0] OFF_CLOCK_WAIT    = 12'h0_00c;
  localparam logic [11:0] OFF_STATUS        = 12'h0_010;
  // page io base register fields
  localparam int IOB_LSB   = 0;
  localparam int FRAME_LSB = 4;
  localparam logic [3:0] IOB_RESET   = 4'h0;
  localparam logic [3:0] FRAME_RESET = 4'h4;
  localparam logic [3:0] FRAME_MAX   = 4'h8;
  // page position register: page n at bits 2n+1:2n
  localparam logic [7:0] POSITION_RESET = 8'h00;
  // misc memory control fields
  localparam int SIZE_LSB = 0;
  localparam int RAS_BIT  = 3;
  localparam int A20_BIT  = 4;
  localparam int EMEN_BIT = 5;
  localparam logic [7:0] MISC_RESET = 8'h00;
  // clock and wait state fields
  localparam int IOWS_LSB  = 0;
  localparam int DMA16_LSB = 2;
  localparam int DMA8_LSB  = 4;
  localparam int XSTB_BIT  = 6;
  localparam int DCLK_BIT  = 7;
  localparam logic [7:0] CLOCK_WAIT_RESET = 8'h00;
  // wait count for local memory while expanded memory is on
  localparam logic [2:0] EMS_MEM_WAITS = 3'h1;
  // row strobe timeout in ns and in clocks of 10 ns, rounded down
  localparam int CLK_PERIOD_NS  = 10;
  localparam int RAS_TIMEOUT_NS = 10000;
  localparam int RAS_TIMEOUT_CYC = RAS_TIMEOUT_NS / CLK_PERIOD_NS;
  // kinds of bus cycle that the wait generator serves
  typedef enum logic [1:0] {
    EWC_CYC_MEM,
    EWC_CYC_IO,
    EWC_CYC_DMA16,
    EWC_CYC_DMA8
  } ewc_cyc_t;
endpackage

// [logic/ewc_wait_gen.sv]
`timescale 1ns/1ns
`default_nettype none
module ewc_wait_gen (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // cycle request
  input  wire logic       i_start,
  input  wire logic [2:0] i_waits,
  input  wire logic       i_tick,
  // status
  output logic            o_busy,
  output logic            o_done
);
  logic [2:0] cnt_q;

  // counts wait periods on each tick, then pulses done once
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q  <= 3'h0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (!o_busy && i_start) begin
        o_busy <= 1'b1;
        cnt_q  <= i_waits;
      end else if (o_busy && i_tick) begin
        if (cnt_q == 3'h0) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 3'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/ewc_bus_peer.sv]
`timescale 1ns/1ns
`default_nettype none
// processor side: one bus cycle at a time, timed from its taking edge to ready
module ewc_bus_peer (
  // clock
  input  wire logic       i_clk,
  // from the block
  input  wire logic       i_cyc_ready,
  // to the block
  output logic            o_cyc_start,
  output logic      [1:0] o_cyc_kind,
  output logic      [2:0] o_mem_waits
);
  // idle at time zero
  initial begin
    o_cyc_start = 1'b0;
    o_cyc_kind  = 2'h0;
    o_mem_waits = 3'h0;
  end
  // kind is scrambled after the taking edge, so a block that samples late is caught
  task automatic run(input logic [1:0] kind, input logic [2:0] mw, output int lat);
    lat = 999;
    @(posedge i_clk);
    o_cyc_start <= 1'b1;
    o_cyc_kind  <= kind;
    o_mem_waits <= mw;
    @(posedge i_clk);
    o_cyc_start <= 1'b0;
    o_cyc_kind  <= ~kind;
    for (int n = 0; n < 200; n++) begin
      @(posedge i_clk);
      #1;
      if (i_cyc_ready === 1'b1) begin
        lat = n;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// [testbench/test_ems_and_waitstate_config.sv]
`timescale 1ns/1ns
`default_nettype none
module test_ems_and_waitstate_config;
  // ==========
  // signals
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        a20_in, page_acc, start, cyc_rdy, a20_out, dclk, xstb, ems_en, ras_to;
  logic [1:0]  kind;
  logic [2:0]  mw, size;
  logic [3:0]  iob, frame;
  logic [7:0]  pos;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          num_errors, n_tests, lat[4], cnt;

  ewc_config uut (
    .i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_cyc_start(start), .i_cyc_kind(kind), .i_mem_waits(mw), .i_processor_addr_line_20(a20_in),
    .i_page_access(page_acc), .o_cyc_ready(cyc_rdy), .o_system_addr_line_20(a20_out),
    .o_page_io_base(iob), .o_frame_base(frame), .o_page_position(pos), .o_expanded_memory_size(size),
    .o_expanded_memory_en(ems_en), .o_ras_timeout(ras_to), .o_dma_clk_en(dclk), .o_dma_ext_strobe_en(xstb)
  );
  ewc_bus_peer peer (.i_clk(clk), .i_cyc_ready(cyc_rdy), .o_cyc_start(start), .o_cyc_kind(kind), .o_mem_waits(mw));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========
  // shared tasks
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  // request is held until pready is sampled high; read data taken at that edge
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int n = 0; n <= 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
      if (n == 20) begin
        chk("apb answer", 32'h0000_0000, 32'h0000_0001);
        stop_test();
      end
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(logic [11:0] a, logic [31:0] exp, logic experr);
    apb(1'b0, a, 32'h0000_0000);
    chk("read data", rd, exp);
    chk("slave error", {31'h0, err}, {31'h0, experr});
  endtask
  // fields follow a write one edge after it lands
  task automatic settle;
    @(posedge clk);
    #1;
  endtask
  task automatic count_dclk;
    cnt = 0;
    repeat (8) begin
      @(posedge clk);
      #1;
      cnt += dclk;
    end
  endtask

  // ==========
  // scenarios
  task automatic t_defaults;
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("field outputs", {iob, frame, pos, size, ems_en, xstb, ras_to, a20_out}, {4'h0, 4'h4, 15'h0000});
    rdchk(ewc_pkg::OFF_PAGE_IO_BASE, 32'h0000_0040, 1'b0);
    rdchk(ewc_pkg::OFF_PAGE_POSITION, 32'h0000_0000, 1'b0);
    rdchk(ewc_pkg::OFF_MISC_MEMORY, 32'h0000_0000, 1'b0);
    rdchk(ewc_pkg::OFF_CLOCK_WAIT, 32'h0000_0000, 1'b0);
    count_dclk();
    chk("dma clock ticks", cnt, 4);
    $display("test defaults done");
  endtask

  task automatic t_map;
    apb(1'b1, ewc_pkg::OFF_PAGE_IO_BASE, 32'h0000_009a);
    settle();
    chk("io base and frame", {iob, frame}, 8'ha8);
    apb(1'b1, ewc_pkg::OFF_PAGE_POSITION, 32'h0000_00e4);
    settle();
    chk("page positions", pos, 8'he4);
    apb(1'b1, ewc_pkg::OFF_PAGE_POSITION, 32'h0000_000c);
    settle();
    chk("page 1 alone", pos, 8'h0c);
    apb(1'b1, 12'h014, 32'h0000_00ff);
    chk("unmapped write", {31'h0, err}, 32'h0000_0001);
    rdchk(12'h014, 32'h0000_0000, 1'b1);
    rdchk(ewc_pkg::OFF_PAGE_IO_BASE, 32'h0000_008a, 1'b0);
    $display("test mapping done");
  endtask

  task automatic t_misc;
    page_acc <= 1'b1;
    repeat (1010) @(posedge clk);
    #1;
    chk("timeout while disabled", ras_to, 1'b0);
    page_acc <= 1'b0;
    apb(1'b1, ewc_pkg::OFF_MISC_MEMORY, 32'h0000_001f);
    settle();
    chk("size and line 20", {size, a20_out}, 4'he);
    page_acc <= 1'b1;
    repeat (ewc_pkg::RAS_TIMEOUT_CYC - 10) @(posedge clk);
    #1;
    chk("timeout early", ras_to, 1'b0);
    repeat (20) @(posedge clk);
    #1;
    chk("timeout reached", ras_to, 1'b1);
    page_acc <= 1'b0;
    apb(1'b1, ewc_pkg::OFF_MISC_MEMORY, 32'h0000_0020);
    settle();
    chk("size, line 20, enable", {size, a20_out, ems_en}, 5'h03);
    a20_in <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("line 20 passes low", a20_out, 1'b0);
    a20_in <= 1'b1;
    $display("test misc done");
  endtask

  // io, dma16 and dma8 waits, each code; io code 11 is the setting software should use
  task automatic t_waits;
    for (int k = 1; k < 4; k++) begin
      for (int c = 0; c < 4; c++) begin
        apb(1'b1, ewc_pkg::OFF_CLOCK_WAIT, 32'h0000_0080 | (c << (2 * k - 2)));
        peer.run(2'(k), 3'h0, lat[c]);
        chk("added waits", lat[c] - lat[0], c);
      end
    end
    apb(1'b1, ewc_pkg::OFF_CLOCK_WAIT, 32'h0000_00c0);
    count_dclk();
    chk("strobe and full clock", {xstb, 4'(cnt)}, 5'h18);
    apb(1'b1, ewc_pkg::OFF_CLOCK_WAIT, 32'h0000_0000);
    settle();
    chk("strobe off", xstb, 1'b0);
    $display("test waits done");
  endtask

  task automatic t_mem;
    apb(1'b1, ewc_pkg::OFF_MISC_MEMORY, 32'h0000_0000);
    peer.run(2'h0, 3'h1, lat[0]);
    peer.run(2'h0, 3'h3, lat[1]);
    chk("memory waits", lat[1] - lat[0], 2);
    apb(1'b1, ewc_pkg::OFF_MISC_MEMORY, 32'h0000_0020);
    peer.run(2'h0, 3'h5, lat[2]);
    chk("one wait with expansion on", lat[2], lat[0]);
    $display("test memory done");
  endtask

  task automatic stop_test;
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // main sequence; the last reset lands with every register written
  initial begin
    {rst, psel, penable, pwrite, page_acc} = 5'h10;
    a20_in = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    t_defaults();
    t_map();
    t_misc();
    t_waits();
    t_mem();
    t_defaults();
    stop_test();
  end
endmodule
`default_nettype wire
